/* File: hw/dpmf_pkg.sv */
// Shared constants, types and helpers of the dual port mailbox file
package dpmf_pkg;

	// ==========================================================
	// Geometry
	localparam int DPMF_WORDS = 16;
	localparam int DPMF_WIDTH = 16;
	localparam int DPMF_GROUP = 4;

	// ==========================================================
	// Word addresses
	localparam logic [3:0] DPMF_ADDR_CMD      = 4'h0;
	localparam logic [3:0] DPMF_ADDR_STATUS   = 4'h1;
	localparam logic [3:0] DPMF_ADDR_PARAM_A  = 4'h2;
	localparam logic [3:0] DPMF_ADDR_PARAM_B  = 4'h3;
	localparam logic [3:0] DPMF_ADDR_APP_BASE = 4'h4;

	// ==========================================================
	// Fields of the host command word
	localparam int DPMF_BIT_TEST_SEL    = 15;
	localparam int DPMF_BIT_HARD_RESET  = 14;
	localparam int DPMF_BIT_DEBUG_START = 3;
	localparam int DPMF_BIT_DBG_EXIT    = 15;
	localparam int DPMF_BIT_DBG_PROCEED = 4;
	localparam int DPMF_BIT_DBG_GO      = 3;
	localparam int DPMF_CTRL_CMD_MSB    = 9;
	localparam int DPMF_TEST_SEL_MSB    = 10;

	// ==========================================================
	// Reset values
	localparam logic [15:0] DPMF_WORD_RESET = 16'h0000;

	// ==========================================================
	// Types
	typedef enum logic [1:0] {
		dpmf_kind_control,
		dpmf_kind_test,
		dpmf_kind_debug
	} dpmf_kind_t;

	// True when at most one bit of w[msb:0] is set
	function automatic logic dpmf_at_most_one(input logic [15:0] w, input int msb);
		int cnt;
		cnt = 0;
		for (int i = 0; i <= msb; i++) begin
			if (w[i])
				cnt = cnt + 1;
		end
		return (cnt <= 1);
	endfunction

endpackage

/* File: hw/dpmf_ram.sv */
// Word array of the mailbox file with host and local write ports
`timescale 1ns/1ps

module dpmf_ram #(
	parameter int WORDS  = 16,
	parameter int WIDTH  = 16,
	parameter int ADDR_W = $clog2(WORDS)
) (
	input  wire logic              mclk,
	input  wire logic              rst,
	input  wire logic              h_we,
	input  wire logic [ADDR_W-1:0] h_addr,
	input  wire logic [WIDTH-1:0]  h_wdata,
	input  wire logic              l_we,
	input  wire logic [ADDR_W-1:0] l_addr,
	input  wire logic [WIDTH-1:0]  l_wdata,
	input  wire logic              clr0,
	output logic      [WIDTH-1:0]  h_rdata,
	output logic      [WIDTH-1:0]  l_rdata
);
	import dpmf_pkg::*;

	if (ADDR_W != $clog2(WORDS))
		$error("dpmf_ram: ADDR_W must match WORDS");

	logic [WIDTH-1:0] mem [WORDS];

	// ==========================================================
	// Per word storage
	for (genvar i = 0; i < WORDS; i++) begin : g_word
		always_ff @(posedge mclk or posedge rst) begin
			if (rst) begin
				mem[i] <= WIDTH'(DPMF_WORD_RESET);
			end else if (h_we && h_addr == ADDR_W'(i)) begin
				mem[i] <= h_wdata;
			end else if (l_we && l_addr == ADDR_W'(i)) begin
				mem[i] <= l_wdata;
			end else if (clr0 && ADDR_W'(i) == ADDR_W'(DPMF_ADDR_CMD)) begin
				mem[i] <= WIDTH'(DPMF_WORD_RESET);
			end
		end
	end

	assign h_rdata = mem[h_addr];
	assign l_rdata = mem[l_addr];

endmodule // dpmf_ram

/* File: hw/dpmf_top.sv */
// Dual port mailbox file: host and local access, command word interpretation
`timescale 1ns/1ps

// Notes on behaviour
// - Sixteen 16-bit words, readable and writable from host and local side.
// - Words 0-3 firmware channel, words 4-15 three application channels.
// - Board control enable bit gates host access to the whole file; local access is not gated.
// - Disabled: host reads of words 1-15 give zero, writes do not store.
// - Disabled: host writes to words 1-15 get no acknowledge, bus times out.
// - Disabled: word 0 writes complete, read zero, bit 14 still resets.
// - Host write of word 0 with bit 15 clear and a bit of 9:0 set while idle is a control command.
// - Bit 15 set on first host access of word 0 selects a test.
// - Control bit 3 enters debug; bits 15, 4 or 3 then leave it.
// - Host setting word 0 bit 14 always raises the local hard reset exception.
// - Hardware reset, software reset or debug go disable non-maskable interrupts.
// - Word 0 is cleared when any command, test or debug operation completes.
// - Each bit of 9:0 is one command; host sets only one per write.
// - Command parameters travel through words two and three.
// - Hard reset starts local power-up in the host cycle, cancelling operations.
module dpmf_top #(
	parameter int WORDS = dpmf_pkg::DPMF_WORDS,
	parameter int WIDTH = dpmf_pkg::DPMF_WIDTH
) (
	input  wire logic                   mclk,
	input  wire logic                   rst,
	input  wire logic                   file_enable,
	input  wire logic                   host_req,
	input  wire logic                   host_we,
	input  wire logic [3:0]             host_addr,
	input  wire logic [WIDTH-1:0]       host_wdata,
	output logic      [WIDTH-1:0]       host_rdata,
	output logic                        host_ack,
	input  wire logic                   loc_req,
	input  wire logic                   loc_we,
	input  wire logic [3:0]             loc_addr,
	input  wire logic [WIDTH-1:0]       loc_wdata,
	output logic      [WIDTH-1:0]       loc_rdata,
	output logic                        loc_ack,
	input  wire logic                   op_done,
	input  wire logic                   sw_reset,
	input  wire logic                   nmi_enable_set,
	output logic                        cmd_strobe,
	output dpmf_pkg::dpmf_kind_t        cmd_kind,
	output logic      [WIDTH-1:0]       cmd_word,
	output logic                        cmd_multi_error,
	output logic                        cmd_busy,
	output logic                        debug_active,
	output logic                        hard_reset_exc,
	output logic                        nmi_enabled
);
	import dpmf_pkg::*;

	localparam int ADDR_W = 4;

	// ==========================================================
	// Elaboration checks
	if (WORDS != DPMF_WORDS)
		$error("dpmf_top: WORDS must be 16");
	if (WIDTH < DPMF_WIDTH)
		$error("dpmf_top: WIDTH must be at least 16");
	if (WORDS % DPMF_GROUP != 0)
		$error("dpmf_top: WORDS must be a multiple of the group size");

	// ==========================================================
	// Interpretation state
	typedef enum logic [1:0] {
		dpmf_st_idle,
		dpmf_st_busy,
		dpmf_st_debug,
		dpmf_st_leave
	} dpmf_state_t;

	dpmf_state_t      state;
	dpmf_state_t      next_state;

	logic             addr_is_cmd;
	logic             host_wr;
	logic             host_refused;
	logic             host_store;
	logic             hard_hit;
	logic             cmd_write;
	logic             new_cmd;
	logic             dbg_leave;
	logic             dbg_go;
	logic             multi_hit;
	dpmf_kind_t       next_kind;
	logic [WIDTH-1:0] ram_h_rdata;
	logic [WIDTH-1:0] ram_l_rdata;

	// ==========================================================
	// Host access decode
	assign addr_is_cmd  = (host_addr == DPMF_ADDR_CMD);
	assign host_wr      = host_req && host_we;
	// Words 1-15 refuse writes while disabled, so no acknowledge is sent
	assign host_refused = host_wr && !file_enable && !addr_is_cmd;
	// Nothing is stored while disabled; word 0 writes still complete
	assign host_store   = host_wr && file_enable;
	// Bit 14 acts in every interpretation and also while disabled
	assign hard_hit     = host_wr && addr_is_cmd && host_wdata[DPMF_BIT_HARD_RESET];
	assign cmd_write    = host_store && addr_is_cmd && !hard_hit;

	// ==========================================================
	// Storage
	dpmf_ram #(
		.WORDS  (WORDS),
		.WIDTH  (WIDTH),
		.ADDR_W (ADDR_W)
	) u_ram (
		.mclk    (mclk),
		.rst     (rst),
		.h_we    (host_store && !hard_hit),
		.h_addr  (host_addr),
		.h_wdata (host_wdata),
		// Hard reset clears word 0 even against a local write in the same cycle
		.l_we    (loc_req && loc_we && !(hard_hit && loc_addr == DPMF_ADDR_CMD)),
		.l_addr  (loc_addr),
		.l_wdata (loc_wdata),
		.clr0    (op_done || hard_hit),
		.h_rdata (ram_h_rdata),
		.l_rdata (ram_l_rdata)
	);

	// ==========================================================
	// Command interpretation
	always_comb begin
		next_state = state;
		next_kind  = cmd_kind;
		new_cmd    = 1'b0;
		dbg_leave  = 1'b0;
		dbg_go     = 1'b0;
		multi_hit  = 1'b0;
		unique case (state)
			dpmf_st_idle: begin
				if (cmd_write && host_wdata[DPMF_BIT_TEST_SEL]) begin
					// First access with bit 15 set selects a test
					next_kind  = dpmf_kind_test;
					new_cmd    = 1'b1;
					multi_hit  = !dpmf_at_most_one(16'(host_wdata), DPMF_TEST_SEL_MSB);
					next_state = dpmf_st_busy;
				end else if (cmd_write && host_wdata[DPMF_CTRL_CMD_MSB:0] != '0) begin
					next_kind  = dpmf_kind_control;
					new_cmd    = 1'b1;
					multi_hit  = !dpmf_at_most_one(16'(host_wdata), DPMF_CTRL_CMD_MSB);
					if (host_wdata[DPMF_BIT_DEBUG_START])
						next_state = dpmf_st_debug;
					else
						next_state = dpmf_st_busy;
				end
			end
			dpmf_st_busy: begin
				if (op_done)
					next_state = dpmf_st_idle;
			end
			dpmf_st_debug: begin
				if (cmd_write) begin
					next_kind = dpmf_kind_debug;
					new_cmd   = 1'b1;
					dbg_go    = host_wdata[DPMF_BIT_DBG_GO];
					dbg_leave = host_wdata[DPMF_BIT_DBG_EXIT]
						|| host_wdata[DPMF_BIT_DBG_PROCEED]
						|| host_wdata[DPMF_BIT_DBG_GO];
					if (dbg_leave)
						next_state = dpmf_st_leave;
				end
			end
			dpmf_st_leave: begin
				if (op_done)
					next_state = dpmf_st_idle;
			end
		endcase
		// Hard reset cancels whatever was running
		if (hard_hit)
			next_state = dpmf_st_idle;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= dpmf_st_idle;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmd_kind <= dpmf_kind_control;
		end else begin
			cmd_kind <= next_kind;
		end
	end

	// ==========================================================
	// Command hand-off to local firmware
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmd_strobe      <= 1'b0;
			cmd_word        <= '0;
			cmd_multi_error <= 1'b0;
		end else begin
			cmd_strobe      <= new_cmd && !hard_hit;
			cmd_multi_error <= new_cmd && multi_hit;
			if (new_cmd)
				cmd_word <= host_wdata;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cmd_busy     <= 1'b0;
			debug_active <= 1'b0;
		end else begin
			cmd_busy     <= (next_state == dpmf_st_busy) || (next_state == dpmf_st_leave);
			debug_active <= (next_state == dpmf_st_debug) || (next_state == dpmf_st_leave);
		end
	end

	// ==========================================================
	// Hard reset exception and interrupt gating
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hard_reset_exc <= 1'b0;
		end else begin
			hard_reset_exc <= hard_hit;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			nmi_enabled <= 1'b0;
		end else if (sw_reset || hard_hit || dbg_go) begin
			nmi_enabled <= 1'b0;
		end else if (nmi_enable_set) begin
			nmi_enabled <= 1'b1;
		end
	end

	// ==========================================================
	// Host answer
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			host_ack   <= 1'b0;
			host_rdata <= '0;
		end else begin
			host_ack <= host_req && !host_refused;
			if (host_req && !host_we) begin
				// Every word reads zero from the host while disabled
				host_rdata <= file_enable ? ram_h_rdata : '0;
			end else if (host_req) begin
				host_rdata <= '0;
			end
		end
	end

	// ==========================================================
	// Local answer
	// Local firmware reaches all words, including the parameter words
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			loc_ack   <= 1'b0;
			loc_rdata <= '0;
		end else begin
			loc_ack <= loc_req;
			if (loc_req && !loc_we)
				loc_rdata <= ram_l_rdata;
		end
	end

endmodule // dpmf_top

/* File: dv/dpmf_host_bfm.sv */
// Host bus master model on the far side of the mailbox file
`timescale 1ns/1ps
module dpmf_host_bfm (
	input  wire logic        mclk,
	input  wire logic        host_ack,
	input  wire logic [15:0] host_rdata,
	output logic             host_req,
	output logic             host_we,
	output logic [3:0]       host_addr,
	output logic [15:0]      host_wdata
);
	initial begin
		host_req = 1'b0;
		host_we = 1'b0;
		host_addr = 4'h0;
		host_wdata = 16'h0000;
	end
	// One request pulse; the answer is taken in the following cycle
	task automatic xfer(input logic we, input logic [3:0] a, input logic [15:0] d,
		output logic ok, output logic [15:0] q);
		@(posedge mclk) #1;
		host_req = 1'b1;
		host_we = we;
		host_addr = a;
		host_wdata = d;
		@(posedge mclk) #1;
		host_req = 1'b0;
		host_addr = ~a;
		host_wdata = ~d;
		ok = host_ack;
		q = host_rdata;
	endtask
endmodule // dpmf_host_bfm

/* File: dv/dpmf_top_assertions.sv */
// Port checker of the mailbox file
`timescale 1ns/1ps
module dpmf_top_assertions
	import dpmf_pkg::*;
#(
	parameter int WORDS = 16,
	parameter int WIDTH = 16
) (
	input wire logic             mclk,
	input wire logic             rst,
	input wire logic             file_enable,
	input wire logic             host_req,
	input wire logic             host_we,
	input wire logic [3:0]       host_addr,
	input wire logic [WIDTH-1:0] host_wdata,
	input wire logic [WIDTH-1:0] host_rdata,
	input wire logic             host_ack,
	input wire logic             loc_req,
	input wire logic             loc_ack,
	input wire logic             op_done,
	input wire logic             sw_reset,
	input wire logic             nmi_enable_set,
	input wire logic             cmd_strobe,
	input wire dpmf_kind_t       cmd_kind,
	input wire logic             cmd_multi_error,
	input wire logic             cmd_busy,
	input wire logic             debug_active,
	input wire logic             hard_reset_exc,
	input wire logic             nmi_enabled
);
	logic w0;
	logic idle_w0;
	assign w0 = host_req && host_we && host_addr == 4'h0;
	assign idle_w0 = w0 && file_enable && !host_wdata[14] && !cmd_busy && !debug_active;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	read_ack_a: assert property (host_req && !host_we |=> host_ack)
		else $error("read without ack");
	loc_ack_a: assert property (loc_req |=> loc_ack)
		else $error("local access without ack");
	off_read_a: assert property (host_req && !host_we && !file_enable |=> host_rdata == 16'h0000)
		else $error("disabled read not zero");
	off_write_a: assert property (host_req && host_we && !file_enable && host_addr != 4'h0
		|=> !host_ack)
		else $error("disabled write acked");
	hard_reset_a: assert property (w0 && host_wdata[14]
		|=> hard_reset_exc && !cmd_strobe && !cmd_busy && !debug_active)
		else $error("hard reset missed");
	test_kind_a: assert property (idle_w0 && host_wdata[15]
		|=> cmd_strobe && cmd_kind == dpmf_kind_test)
		else $error("test word not taken");
	multi_cmd_a: assert property (idle_w0 && !host_wdata[15] && $countones(host_wdata[9:0]) > 1
		|=> cmd_strobe && cmd_multi_error)
		else $error("multiple commands not flagged");
	done_idle_a: assert property (op_done && !host_req && !loc_req |=> !cmd_busy)
		else $error("busy after done");
	dbg_kind_a: assert property (w0 && file_enable && debug_active && !cmd_busy && !host_wdata[14]
		|=> cmd_strobe && cmd_kind == dpmf_kind_debug)
		else $error("debug command not taken");
	nmi_off_a: assert property ((sw_reset || (w0 && file_enable && debug_active && !cmd_busy
		&& host_wdata[3])) && !nmi_enable_set |=> !nmi_enabled)
		else $error("nmi left enabled");
	cover property (cmd_strobe && cmd_kind == dpmf_kind_test);
	cover property (hard_reset_exc);
	cover property ($rose(debug_active));
	cover property (host_req && host_we && !file_enable && host_addr != 4'h0);
endmodule // dpmf_top_assertions

bind dpmf_top dpmf_top_assertions #(.WORDS(WORDS), .WIDTH(WIDTH)) chk_u (
	.mclk(mclk), .rst(rst), .file_enable(file_enable), .host_req(host_req),
	.host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
	.host_rdata(host_rdata), .host_ack(host_ack), .loc_req(loc_req), .loc_ack(loc_ack),
	.op_done(op_done), .sw_reset(sw_reset), .nmi_enable_set(nmi_enable_set),
	.cmd_strobe(cmd_strobe), .cmd_kind(cmd_kind), .cmd_multi_error(cmd_multi_error),
	.cmd_busy(cmd_busy), .debug_active(debug_active), .hard_reset_exc(hard_reset_exc),
	.nmi_enabled(nmi_enabled));

/* File: dv/dpmf_top_test.sv */
// Self-checking bench of the mailbox file
`timescale 1ns/1ps
module dpmf_top_test;
	import dpmf_pkg::*;
	logic        mclk, rst, file_enable, op_done, sw_reset, nmi_enable_set, ok;
	logic        host_req, host_we, host_ack, loc_req, loc_we, loc_ack;
	logic        cmd_strobe, cmd_multi_error, cmd_busy, debug_active, hard_reset_exc;
	logic        nmi_enabled;
	logic [3:0]  host_addr, loc_addr;
	logic [15:0] host_wdata, host_rdata, loc_wdata, loc_rdata, cmd_word, q, w;
	logic [15:0] mem [16];
	dpmf_kind_t  cmd_kind;
	int          failures, num_checks, seed;
	dpmf_top dut_u (.mclk(mclk), .rst(rst), .file_enable(file_enable), .host_req(host_req),
		.host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata),
		.host_rdata(host_rdata), .host_ack(host_ack), .loc_req(loc_req), .loc_we(loc_we),
		.loc_addr(loc_addr), .loc_wdata(loc_wdata), .loc_rdata(loc_rdata), .loc_ack(loc_ack),
		.op_done(op_done), .sw_reset(sw_reset), .nmi_enable_set(nmi_enable_set),
		.cmd_strobe(cmd_strobe), .cmd_kind(cmd_kind), .cmd_word(cmd_word),
		.cmd_multi_error(cmd_multi_error), .cmd_busy(cmd_busy), .debug_active(debug_active),
		.hard_reset_exc(hard_reset_exc), .nmi_enabled(nmi_enabled));
	dpmf_host_bfm host_u (.mclk(mclk), .host_ack(host_ack), .host_rdata(host_rdata),
		.host_req(host_req), .host_we(host_we), .host_addr(host_addr), .host_wdata(host_wdata));
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	function automatic dpmf_kind_t ekind(input logic [15:0] v);
		return v[15] ? dpmf_kind_test : dpmf_kind_control;
	endfunction
	function automatic logic emulti(input logic [15:0] v);
		return $countones(v[15] ? v[10:0] : {1'b0, v[9:0]}) > 1;
	endfunction
	task automatic chk(input logic c, input string m);
		num_checks++;
		if (!c) begin
			failures++;
			$display("BAD %0t %s", $time, m);
		end
	endtask
	task automatic hx(input logic we, input logic [3:0] a, input logic [15:0] d);
		host_u.xfer(we, a, d, ok, q);
	endtask
	task automatic lx(input logic we, input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk) #1;
		{loc_req, loc_we, loc_addr, loc_wdata} = {1'b1, we, a, d};
		@(posedge mclk) #1;
		{loc_req, loc_addr, loc_wdata} = {1'b0, ~a, ~d};
	endtask
	task automatic pulse(ref logic s);
		@(posedge mclk) #1 s = 1'b1;
		@(posedge mclk) #1 s = 1'b0;
	endtask
	task automatic report_and_stop();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		#200us;
		failures++;
		report_and_stop();
	end
	initial begin
		seed = 32'h0255;
		{rst, file_enable, op_done, sw_reset, nmi_enable_set, loc_req, loc_we} = 7'h40;
		{loc_addr, loc_wdata} = 20'h00000;
		repeat (8) @(posedge mclk);
		#1 rst = 1'b0;
		chk(cmd_kind === dpmf_kind_control && nmi_enabled === 1'b0 && host_ack === 1'b0
			&& cmd_strobe === 1'b0 && cmd_busy === 1'b0 && debug_active === 1'b0
			&& hard_reset_exc === 1'b0, "reset state");
		file_enable = 1'b1;
		for (int i = 1; i < 16; i++) begin
			mem[i] = $random(seed);
			hx(1'b1, i[3:0], mem[i]);
			chk(ok === 1'b1, "write ack");
		end
		for (int i = 1; i < 16; i++) begin
			hx(1'b0, i[3:0], 16'h0000);
			chk(q === mem[i], "host read");
			lx(1'b0, i[3:0], 16'h0000);
			chk(loc_rdata === mem[i], "local read");
		end
		fork
			hx(1'b1, 4'h5, 16'ha5a5);
			lx(1'b1, 4'h5, 16'h1111);
		join
		hx(1'b0, 4'h5, 16'h0000);
		chk(q === 16'ha5a5, "collision");
		$display("done: file access");
		file_enable = 1'b0;
		hx(1'b0, 4'h6, 16'h0000);
		chk(ok === 1'b1 && q === 16'h0000, "disabled read");
		hx(1'b1, 4'h6, ~mem[6]);
		chk(ok === 1'b0, "disabled write");
		hx(1'b1, 4'h0, 16'h4000);
		chk(ok === 1'b1 && hard_reset_exc === 1'b1, "disabled reset");
		hx(1'b0, 4'h0, 16'h0000);
		chk(q === 16'h0000, "word0 off");
		file_enable = 1'b1;
		hx(1'b0, 4'h6, 16'h0000);
		chk(q === mem[6], "kept");
		$display("done: enable gate");
		for (int i = 0; i < 22; i++) begin
			w = (i < 10) ? 16'h0001 << i : 16'h8000 | (16'h0001 << (i - 10));
			if (i == 21)
				w = 16'h0003;
			if (i != 3) begin
				hx(1'b1, 4'h0, w);
				chk(cmd_strobe === 1'b1 && cmd_kind === ekind(w), "kind");
				chk(cmd_word === w && cmd_multi_error === emulti(w), "word");
				lx(1'b1, 4'h2, ~w);
				hx(1'b0, 4'h2, 16'h0000);
				chk(q === ~w, "param");
				hx(1'b1, 4'h0, 16'h0010);
				chk(cmd_strobe === 1'b0 && cmd_busy === 1'b1, "busy");
				pulse(op_done);
				hx(1'b0, 4'h0, 16'h0000);
				chk(q === 16'h0000 && cmd_busy === 1'b0, "cleared");
			end
		end
		$display("done: commands");
		pulse(nmi_enable_set);
		hx(1'b1, 4'h0, 16'h0008);
		pulse(op_done);
		chk(debug_active === 1'b1 && nmi_enabled === 1'b1, "debug entry");
		hx(1'b1, 4'h0, 16'h0008);
		chk(nmi_enabled === 1'b0 && cmd_strobe === 1'b1 && cmd_kind === dpmf_kind_debug, "go");
		pulse(op_done);
		chk(debug_active === 1'b0, "debug exit");
		pulse(nmi_enable_set);
		pulse(sw_reset);
		chk(nmi_enabled === 1'b0, "sw reset");
		$display("done: debug");
		hx(1'b1, 4'h0, 16'h0004);
		hx(1'b1, 4'h0, 16'h4000);
		chk(hard_reset_exc === 1'b1 && cmd_busy === 1'b0, "reset cancels");
		$display("done: hard reset");
		report_and_stop();
	end
endmodule // dpmf_top_test
